// ---- hdl/gear_pkg.sv ----
package gear_pkg;

    localparam int ERR_W = 32;
    localparam int DELTA_W = 18;
    localparam int GEAR_W = 16;
    localparam int PEND_W = 8;

    localparam logic [7:0] ADDR_GEAR_NUM = 8'h00;
    localparam logic [7:0] ADDR_GEAR_DEN = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_ERROR = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_ACTIVE_GEAR = 8'h14;

    localparam logic [GEAR_W-1:0] GEAR_NUM_RESET = 16'h0001;
    localparam logic [GEAR_W-1:0] GEAR_DEN_RESET = 16'h0001;
    localparam logic [1:0] CLEAR_MODE_RESET = 2'h0;
    localparam logic FILTER_RESET = 1'h0;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_FILTER_BIT = 2;
    localparam int CTRL_RESTART_BIT = 8;

    localparam int STAT_LOOP_BIT = 0;
    localparam int STAT_CLEAR_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;
    localparam int STAT_SERVO_BIT = 3;
    localparam int STAT_PEND_LSB = 8;

    localparam logic [4:0] DIV_LAST_STEP = 5'h10;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {CLR_ON_SOFF, CLR_NEVER, CLR_SOFF_OR_OT} clear_mode_t;
    typedef enum logic {DIV_IDLE, DIV_RUN} div_state_t;

endpackage : gear_pkg

// ---- hdl/gear_scaler.sv ----
`timescale 1ns/1ps
module gear_scaler (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic en,
    input wire logic restart,
    input wire logic start,
    input wire logic dir,
    input wire logic [gear_pkg::GEAR_W-1:0] num,
    input wire logic [gear_pkg::GEAR_W-1:0] den,
    output logic busy,
    output logic done,
    output logic signed [gear_pkg::DELTA_W-1:0] delta,
    output logic [gear_pkg::GEAR_W-1:0] remainder
);
    import gear_pkg::*;

    div_state_t state_q;
    logic [16:0] acc_q;
    logic [16:0] part_q;
    logic [16:0] t_hold_q;
    logic [4:0] cnt_q;
    logic dir_q;
    logic [15:0] den_m1;
    logic [16:0] t_start;
    logic [16:0] trial;
    logic ge;
    logic [16:0] part_n;
    logic [16:0] acc_n;

    // Reverse steps work on the mirrored remainder so one unsigned divider serves both signs.
    always_comb begin
        den_m1 = den - 16'h0001;
        t_start = dir ? {1'h0, num} + {1'h0, remainder}
                      : {1'h0, num} + {1'h0, den_m1 - remainder};
        trial = {part_q[15:0], acc_q[16]};
        ge = trial >= {1'h0, den};
        part_n = ge ? trial - {1'h0, den} : trial;
        acc_n = {acc_q[15:0], ge};
    end

    assign busy = (state_q == DIV_RUN);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= DIV_IDLE;
            acc_q <= 17'h00000;
            part_q <= 17'h00000;
            t_hold_q <= 17'h00000;
            cnt_q <= 5'h00;
            dir_q <= 1'h0;
            done <= 1'h0;
            delta <= 18'h00000;
            remainder <= 16'h0000;
        end else if (en) begin
            done <= 1'h0;
            if (restart) begin
                state_q <= DIV_IDLE;
                remainder <= 16'h0000;
            end else begin
                case (state_q)
                    DIV_IDLE: begin
                        if (start) begin
                            acc_q <= t_start;
                            t_hold_q <= t_start;
                            part_q <= 17'h00000;
                            cnt_q <= 5'h00;
                            dir_q <= dir;
                            state_q <= DIV_RUN;
                        end
                    end
                    DIV_RUN: begin
                        acc_q <= acc_n;
                        part_q <= part_n;
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == DIV_LAST_STEP) begin
                            state_q <= DIV_IDLE;
                            done <= 1'h1;
                            delta <= dir_q ? {1'h0, acc_n} : ~{1'h0, acc_n} + 18'h00001;
                            remainder <= dir_q ? part_n[15:0] : den_m1 - part_n[15:0];
                        end
                    end
                    default: state_q <= DIV_IDLE;
                endcase
            end
        end
    end

    a_div_forward: assert property (@(posedge clk) disable iff (!arst_n)
        done && dir_q |-> 34'(delta) * 34'(den) + 34'(remainder) == 34'(t_hold_q))
        else $error("forward gear scaling result is wrong");

    a_div_reverse: assert property (@(posedge clk) disable iff (!arst_n)
        done && !dir_q |-> 34'(-delta) * 34'(den) + 34'(den_m1 - remainder) == 34'(t_hold_q))
        else $error("reverse gear scaling result is wrong");

    a_rem_bound: assert property (@(posedge clk) disable iff (!arst_n)
        remainder < den)
        else $error("carried remainder not below denominator");

endmodule : gear_scaler

// ---- hdl/error_counter.sv ----
`timescale 1ns/1ps
module error_counter (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic en,
    input wire logic clear,
    input wire logic add_valid,
    input wire logic signed [gear_pkg::DELTA_W-1:0] add_delta,
    input wire logic fb_step,
    input wire logic fb_dir,
    output logic signed [gear_pkg::ERR_W-1:0] error
);
    import gear_pkg::*;

    logic [ERR_W-1:0] add_term;
    logic [ERR_W-1:0] fb_term;

    always_comb begin
        add_term = add_valid ? {{(ERR_W-DELTA_W){add_delta[DELTA_W-1]}}, add_delta} : 32'h00000000;
        fb_term = !fb_step ? 32'h00000000 : (fb_dir ? 32'h00000001 : 32'hFFFFFFFF);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            error <= 32'h00000000;
        end else if (en) begin
            if (clear) begin
                error <= 32'h00000000;
            end else begin
                error <= error + add_term - fb_term;
            end
        end
    end

    a_fb_count: assert property (@(posedge clk) disable iff (!arst_n)
        en && !clear && !add_valid && fb_step && fb_dir |=> error == $past(error) - 32'h00000001)
        else $error("forward feedback count not taken from error");

endmodule : error_counter

// ---- hdl/position_error_clear_and_gear.sv ----
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
// Contract
// - Clear input low forces error counter zero.
// - Clear input low suspends position loop correction.
// - Servo-off keeps accumulated pulses unless mode flushes.
// - First mode clears at servo-off entry, not overtravel.
// - No-clear mode never clears automatically.
// - Third mode clears at servo-off or unclamped overtravel.
// - Reference pulse scaled by numerator over denominator.
// - Direction high forward, low reverse, steps counted.
module position_error_clear_and_gear (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic ref_step,
    input wire logic ref_dir,
    input wire logic fb_step,
    input wire logic fb_dir,
    input wire logic error_clear_n,
    input wire logic servo_on,
    input wire logic overtravel,
    input wire logic zero_clamp,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic signed [gear_pkg::ERR_W-1:0] position_error,
    output logic signed [gear_pkg::ERR_W-1:0] position_correction,
    output logic loop_enable,
    output logic noise_filter_en
);
    import gear_pkg::*;

    logic [GEAR_W-1:0] gear_numerator_q;
    logic [GEAR_W-1:0] gear_denominator_q;
    logic [GEAR_W-1:0] gear_num_act_q;
    logic [GEAR_W-1:0] gear_den_act_q;
    logic [1:0] clear_mode_select_q;
    logic [7:0] awaddr_q;
    logic aw_have_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_have_q;
    logic servo_on_prev_q;
    logic [PEND_W-1:0] pend_q;
    logic [PEND_W-1:0] pend_d;
    logic do_write;
    logic restart;
    logic start;
    logic clear_now;
    logic auto_clear;
    clear_mode_t clear_mode;
    logic [31:0] rd_word;
    logic scaler_busy;
    logic scaler_done;
    logic signed [DELTA_W-1:0] scaler_delta;
    logic [GEAR_W-1:0] scaler_rem;

    function automatic logic is_mapped(input logic [7:0] addr);
        if (addr == ADDR_GEAR_NUM) begin
            return 1'h1;
        end else if (addr == ADDR_GEAR_DEN) begin
            return 1'h1;
        end else if (addr == ADDR_CONTROL) begin
            return 1'h1;
        end else if (addr == ADDR_ERROR) begin
            return 1'h1;
        end else if (addr == ADDR_STATUS) begin
            return 1'h1;
        end else if (addr == ADDR_ACTIVE_GEAR) begin
            return 1'h1;
        end else begin
            return 1'h0;
        end
    endfunction : is_mapped

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction : merge16

    // A zero denominator would give the divider no valid quotient or remainder, so a zero gear value is applied as one.
    function automatic logic [15:0] nonzero16(input logic [15:0] v);
        return (v == 16'h0000) ? 16'h0001 : v;
    endfunction : nonzero16

    function automatic clear_mode_t decode_mode(input logic [1:0] raw);
        case (raw)
            2'h0: return CLR_ON_SOFF;
            2'h2: return CLR_SOFF_OR_OT;
            default: return CLR_NEVER;
        endcase
    endfunction : decode_mode

    assign do_write = aw_have_q && w_have_q && !bvalid;
    assign restart = do_write && (awaddr_q == ADDR_CONTROL) && wstrb_q[1]
                     && wdata_q[CTRL_RESTART_BIT];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            awready <= 1'h1;
            aw_have_q <= 1'h0;
            awaddr_q <= 8'h00;
        end else if (clk_en) begin
            if (awvalid && awready) begin
                awaddr_q <= awaddr;
                aw_have_q <= 1'h1;
                awready <= 1'h0;
            end else if (do_write) begin
                aw_have_q <= 1'h0;
            end else if (bvalid && bready) begin
                awready <= 1'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wready <= 1'h1;
            w_have_q <= 1'h0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else if (clk_en) begin
            if (wvalid && wready) begin
                wdata_q <= wdata;
                wstrb_q <= wstrb;
                w_have_q <= 1'h1;
                wready <= 1'h0;
            end else if (do_write) begin
                w_have_q <= 1'h0;
            end else if (bvalid && bready) begin
                wready <= 1'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bvalid <= 1'h0;
            bresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (do_write) begin
                bvalid <= 1'h1;
                bresp <= is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'h0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gear_numerator_q <= GEAR_NUM_RESET;
            gear_denominator_q <= GEAR_DEN_RESET;
            clear_mode_select_q <= CLEAR_MODE_RESET;
            noise_filter_en <= FILTER_RESET;
        end else if (clk_en && do_write) begin
            if (awaddr_q == ADDR_GEAR_NUM) begin
                gear_numerator_q <= merge16(gear_numerator_q, wdata_q, wstrb_q);
            end else if (awaddr_q == ADDR_GEAR_DEN) begin
                gear_denominator_q <= merge16(gear_denominator_q, wdata_q, wstrb_q);
            end else if (awaddr_q == ADDR_CONTROL && wstrb_q[0]) begin
                clear_mode_select_q <= wdata_q[CTRL_MODE_LSB +: 2];
                noise_filter_en <= wdata_q[CTRL_FILTER_BIT];
            end
        end
    end

    // Written gear values stay inactive until software issues a restart.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gear_num_act_q <= GEAR_NUM_RESET;
            gear_den_act_q <= GEAR_DEN_RESET;
        end else if (clk_en && restart) begin
            gear_num_act_q <= nonzero16(gear_numerator_q);
            gear_den_act_q <= nonzero16(gear_denominator_q);
        end
    end

    always_comb begin
        rd_word = 32'h00000000;
        if (araddr == ADDR_GEAR_NUM) begin
            rd_word[15:0] = gear_numerator_q;
        end else if (araddr == ADDR_GEAR_DEN) begin
            rd_word[15:0] = gear_denominator_q;
        end else if (araddr == ADDR_CONTROL) begin
            rd_word[CTRL_MODE_LSB +: 2] = clear_mode_select_q;
            rd_word[CTRL_FILTER_BIT] = noise_filter_en;
        end else if (araddr == ADDR_ERROR) begin
            rd_word = position_error;
        end else if (araddr == ADDR_STATUS) begin
            rd_word[STAT_LOOP_BIT] = loop_enable;
            rd_word[STAT_CLEAR_BIT] = clear_now;
            rd_word[STAT_BUSY_BIT] = scaler_busy;
            rd_word[STAT_SERVO_BIT] = servo_on;
            rd_word[STAT_PEND_LSB +: PEND_W] = pend_q;
        end else if (araddr == ADDR_ACTIVE_GEAR) begin
            rd_word = {gear_den_act_q, gear_num_act_q};
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            arready <= 1'h1;
            rvalid <= 1'h0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (arvalid && arready) begin
                arready <= 1'h0;
                rvalid <= 1'h1;
                rdata <= rd_word;
                rresp <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'h0;
                arready <= 1'h1;
            end
        end
    end

    assign clear_mode = decode_mode(clear_mode_select_q);

    always_comb begin
        case (clear_mode)
            CLR_ON_SOFF: auto_clear = servo_on_prev_q && !servo_on;
            CLR_SOFF_OR_OT: auto_clear = !servo_on || (overtravel && !zero_clamp);
            default: auto_clear = 1'h0;
        endcase
    end

    assign clear_now = !error_clear_n || auto_clear;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            servo_on_prev_q <= 1'h0;
        end else if (clk_en) begin
            servo_on_prev_q <= servo_on;
        end
    end

    // Reference steps queue here while the divider works on an earlier one.
    always_comb begin
        start = !scaler_busy && (pend_q != 8'h00);
        pend_d = pend_q;
        if (ref_step) begin
            pend_d = ref_dir ? pend_d + 8'h01 : pend_d - 8'h01;
        end
        if (start) begin
            pend_d = pend_q[PEND_W-1] ? pend_d + 8'h01 : pend_d - 8'h01;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_q <= 8'h00;
        end else if (clk_en) begin
            pend_q <= pend_d;
        end
    end

    gear_scaler u_scaler (
        .clk(clk),
        .arst_n(arst_n),
        .en(clk_en),
        .restart(restart),
        .start(start),
        .dir(!pend_q[PEND_W-1]),
        .num(gear_num_act_q),
        .den(gear_den_act_q),
        .busy(scaler_busy),
        .done(scaler_done),
        .delta(scaler_delta),
        .remainder(scaler_rem)
    );

    error_counter u_error (
        .clk(clk),
        .arst_n(arst_n),
        .en(clk_en),
        .clear(clear_now),
        .add_valid(scaler_done),
        .add_delta(scaler_delta),
        .fb_step(fb_step),
        .fb_dir(fb_dir),
        .error(position_error)
    );

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            loop_enable <= 1'h0;
            position_correction <= 32'h00000000;
        end else if (clk_en) begin
            loop_enable <= error_clear_n && servo_on;
            position_correction <= (error_clear_n && servo_on) ? position_error : 32'h00000000;
        end
    end

    a_clear_zero: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && !error_clear_n |=> position_error == 32'h00000000)
        else $error("error counter not zero while clear held");

    a_loop_off: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && !error_clear_n |=> !loop_enable && position_correction == 32'h00000000)
        else $error("position loop still active while clear held");

    a_soff_keep: assert property (@(posedge clk) disable iff (!arst_n)
        clear_mode == CLR_ON_SOFF && !servo_on && !servo_on_prev_q && error_clear_n
        |-> !clear_now)
        else $error("pulses flushed during servo-off after entry");

    a_soff_entry: assert property (@(posedge clk) disable iff (!arst_n)
        clear_mode == CLR_ON_SOFF && clk_en && servo_on_prev_q && !servo_on
        |=> position_error == 32'h00000000)
        else $error("servo-off entry did not clear error");

    a_ot_kept: assert property (@(posedge clk) disable iff (!arst_n)
        clear_mode == CLR_ON_SOFF && servo_on && servo_on_prev_q && overtravel && error_clear_n
        |-> !clear_now)
        else $error("overtravel cleared error in first mode");

    a_never_auto: assert property (@(posedge clk) disable iff (!arst_n)
        clear_mode == CLR_NEVER && error_clear_n |-> !clear_now)
        else $error("automatic clear in no-clear mode");

    a_ot_flush: assert property (@(posedge clk) disable iff (!arst_n)
        clear_mode == CLR_SOFF_OR_OT && clk_en && (!servo_on || (overtravel && !zero_clamp))
        |=> position_error == 32'h00000000)
        else $error("third mode did not flush error");

    a_clamp_kept: assert property (@(posedge clk) disable iff (!arst_n)
        clear_mode == CLR_SOFF_OR_OT && servo_on && overtravel && zero_clamp && error_clear_n
        |-> !clear_now)
        else $error("overtravel under zero clamp cleared error");

    a_dir_fwd: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && ref_step && ref_dir && !start |=> pend_q == $past(pend_q) + 8'h01)
        else $error("forward reference step not counted up");

endmodule : position_error_clear_and_gear

// ---- testbench/host_pulse_model.sv ----
`timescale 1ns/1ps
module host_pulse_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic fire,
    input wire logic fire_dir,
    output logic ref_step,
    output logic ref_dir
);
    // Direction means something only beside a step, so between steps it toggles every cycle.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_step <= 1'b0;
            ref_dir <= 1'b0;
        end else if (fire) begin
            ref_step <= 1'b1;
            ref_dir <= fire_dir;
        end else begin
            ref_step <= 1'b0;
            ref_dir <= ~ref_dir;
        end
    end
endmodule : host_pulse_model

// ---- testbench/test_position_error_clear_and_gear.sv ----
`timescale 1ns/1ps
module test_position_error_clear_and_gear;
    import gear_pkg::*;
    logic clk, arst_n, fire, fire_dir, ref_step, ref_dir, fb_step, fb_dir;
    logic error_clear_n, servo_on, overtravel, zero_clamp, clk_en;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic signed [ERR_W-1:0] position_error, position_correction, exp_err;
    logic loop_enable, noise_filter_en;
    int n_fail, check_count, cycles;

    position_error_clear_and_gear u_dut (
        .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .ref_step(ref_step), .ref_dir(ref_dir),
        .fb_step(fb_step), .fb_dir(fb_dir), .error_clear_n(error_clear_n),
        .servo_on(servo_on), .overtravel(overtravel), .zero_clamp(zero_clamp),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .position_error(position_error),
        .position_correction(position_correction), .loop_enable(loop_enable),
        .noise_filter_en(noise_filter_en)
    );

    host_pulse_model u_host (
        .clk(clk), .arst_n(arst_n), .fire(fire), .fire_dir(fire_dir),
        .ref_step(ref_step), .ref_dir(ref_dir)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task test_done();
        $display("Checks %0d, mismatches %0d.", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_fail++;
            test_done();
        end
    end

    task check_val(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check_val

    task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        check_val("bresp", bresp, er);
    endtask : axi_wr

    task axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        check_val("rdata", rdata, exp);
        check_val("rresp", rresp, er);
    endtask : axi_rd

    // Waits out the fixed scaler latency of about 18 cycles before the caller looks.
    task host_step(input logic d);
        @(posedge clk);
        fire <= 1'b1;
        fire_dir <= d;
        @(posedge clk);
        fire <= 1'b0;
        repeat (25) @(posedge clk);
    endtask : host_step

    task fb_pulse(input logic d);
        @(posedge clk);
        fb_step <= 1'b1;
        fb_dir <= d;
        @(posedge clk);
        fb_step <= 1'b0;
        fb_dir <= ~d;
        repeat (3) @(posedge clk);
        exp_err = d ? exp_err - 1 : exp_err + 1;
        check_val("position_error", position_error, exp_err);
    endtask : fb_pulse

    task mode_case(input logic [31:0] ctl, input logic ot_clr, input logic off_clr,
            input logic clamp);
        axi_wr(ADDR_CONTROL, ctl, RESP_OKAY);
        check_val("noise_filter_en", noise_filter_en, ctl[CTRL_FILTER_BIT]);
        fb_pulse(1'b0);
        zero_clamp <= clamp;
        overtravel <= 1'b1;
        repeat (3) @(posedge clk);
        exp_err = ot_clr ? 0 : exp_err;
        check_val("error_after_ot", position_error, exp_err);
        overtravel <= 1'b0;
        zero_clamp <= 1'b0;
        fb_pulse(1'b0);
        servo_on <= 1'b0;
        repeat (3) @(posedge clk);
        exp_err = off_clr ? 0 : exp_err;
        check_val("error_after_off", position_error, exp_err);
        check_val("correction_off", position_correction, 32'h0000_0000);
        servo_on <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : mode_case

    initial begin
        arst_n = 1'b0;
        {fire, fire_dir, fb_step, fb_dir, overtravel, zero_clamp} = 6'h00;
        {error_clear_n, servo_on, clk_en} = 3'h7;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'hF;
        exp_err = 0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        axi_rd(ADDR_GEAR_NUM, 32'h0000_0001, RESP_OKAY);
        axi_rd(ADDR_GEAR_DEN, 32'h0000_0001, RESP_OKAY);
        axi_rd(8'h40, 32'h0000_0000, RESP_SLVERR);
        axi_wr(8'h40, 32'h0000_00FF, RESP_SLVERR);
        host_step(1'b1);
        check_val("error_fwd", position_error, 32'h0000_0001);
        host_step(1'b0);
        check_val("error_rev", position_error, 32'h0000_0000);
        fb_pulse(1'b1);
        error_clear_n <= 1'b0;
        // A reverse step is used so that the counter would read -2 if the clear did nothing.
        host_step(1'b0);
        check_val("error_clear", position_error, 32'h0000_0000);
        check_val("loop_clear", loop_enable, 1'b0);
        check_val("correction_clear", position_correction, 32'h0000_0000);
        axi_rd(ADDR_STATUS, 32'h0000_000A, RESP_OKAY);
        error_clear_n <= 1'b1;
        exp_err = 0;
        axi_wr(ADDR_GEAR_NUM, 32'h0000_0003, RESP_OKAY);
        axi_wr(ADDR_GEAR_DEN, 32'h0000_0002, RESP_OKAY);
        axi_rd(ADDR_ACTIVE_GEAR, 32'h0001_0001, RESP_OKAY);
        axi_wr(ADDR_CONTROL, 32'h0000_0101, RESP_OKAY);
        axi_rd(ADDR_ACTIVE_GEAR, 32'h0002_0003, RESP_OKAY);
        host_step(1'b1);
        check_val("error_gear1", position_error, 32'h0000_0001);
        host_step(1'b1);
        check_val("error_gear2", position_error, 32'h0000_0003);
        check_val("loop_on", loop_enable, 1'b1);
        check_val("correction_on", position_correction, 32'h0000_0003);
        axi_rd(ADDR_ERROR, 32'h0000_0003, RESP_OKAY);
        // A feedback count offered while the clock enable is low must not be taken.
        clk_en <= 1'b0;
        fb_step <= 1'b1;
        @(posedge clk);
        fb_step <= 1'b0;
        repeat (2) @(posedge clk);
        clk_en <= 1'b1;
        check_val("error_frozen", position_error, 32'h0000_0003);
        exp_err = 3;
        mode_case(32'h0000_0000, 1'b0, 1'b1, 1'b0);
        mode_case(32'h0000_0005, 1'b0, 1'b0, 1'b0);
        mode_case(32'h0000_0002, 1'b1, 1'b1, 1'b0);
        mode_case(32'h0000_0002, 1'b0, 1'b1, 1'b1);
        mode_case(32'h0000_0003, 1'b0, 1'b0, 1'b0);
        test_done();
    end
endmodule : test_position_error_clear_and_gear
